// ===== logic/iex_integer_execute.sv
// Purpose: Integer execute unit: decode, execute and ALU writeback stages.
// Assumes: Operands come from logic on aclk; one instruction in flight.
// Notes: Software sees flags, condition fields and the MQ register (DIV or DIVS remainder, zero after DIVW or DIVWU, or low product).
`include "iex_cfg.svh"
module iex_integer_execute (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic issue_valid,
    output logic issue_ready,
    input wire iex_pkg::iex_op_e issue_op,
    input wire logic [4:0] issue_dest,
    input wire logic [31:0] issue_ra,
    input wire logic [31:0] issue_rb,
    input wire logic [15:0] issue_imm,
    input wire logic issue_ra_is_r0,
    input wire logic issue_record,
    input wire logic issue_oe,
    input wire logic [4:0] issue_field,
    output logic wb_valid,
    output logic [4:0] wb_dest,
    output logic [31:0] wb_data,
    output logic cr_fwd_valid,
    output logic [2:0] cr_fwd_field,
    output logic [3:0] cr_fwd_value,
    output logic trap_exception,
    output logic irq,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    iex_pkg::iex_state_e st_reg;
    iex_pkg::iex_op_e op_reg;
    logic [31:0] a_reg, b_reg, mq_reg, wd_reg;
    logic [4:0] dest_reg, fld_reg;
    logic rc_reg, oe_reg, ca_reg, ov_reg, so_reg;
    logic [5:0] cnt_reg, exe_n, wb_n;
    logic [0:7][3:0] cr_reg;
    logic [2:0] status_reg, mask_reg;
    logic [7:0] aw_reg;
    logic [3:0] ws_reg;
    wire take = issue_valid && issue_ready;
    wire imm_in = issue_op inside {[iex_pkg::OP_ADDI:iex_pkg::OP_ADDIS],
        [iex_pkg::OP_ADDIC:iex_pkg::OP_SUBFIC], iex_pkg::OP_MULLI,
        [iex_pkg::OP_CMPI:iex_pkg::OP_CMPLI], iex_pkg::OP_TWI};
    wire [31:0] simm = {{16{issue_imm[15]}}, issue_imm};
    wire [31:0] b_in = !imm_in ? issue_rb
        : issue_op == iex_pkg::OP_ADDIS ? {issue_imm, 16'h0000}
        : issue_op == iex_pkg::OP_CMPLI ? {16'h0000, issue_imm} : simm;
    wire r0_zero = issue_ra_is_r0 && issue_op inside {[iex_pkg::OP_ADDI:iex_pkg::OP_ADD]};
    wire is_add = op_reg inside {[iex_pkg::OP_ADDI:iex_pkg::OP_NEG]};
    wire is_mul = op_reg inside {[iex_pkg::OP_MUL:iex_pkg::OP_MULHWU]};
    wire is_mulli = op_reg == iex_pkg::OP_MULLI;
    wire is_div = op_reg inside {[iex_pkg::OP_DIV:iex_pkg::OP_DIVWU]};
    wire is_cmp = op_reg inside {[iex_pkg::OP_CMP:iex_pkg::OP_CMPLI]};
    wire is_trap = op_reg inside {iex_pkg::OP_TW, iex_pkg::OP_TWI};
    wire imf = op_reg inside {[iex_pkg::OP_ADDI:iex_pkg::OP_ADDIS],
        [iex_pkg::OP_ADDIC:iex_pkg::OP_SUBFIC], iex_pkg::OP_MULLI};
    wire xi = op_reg inside {iex_pkg::OP_SUBFIC, iex_pkg::OP_SUBFC, iex_pkg::OP_SUBFE,
        iex_pkg::OP_SUBFME, iex_pkg::OP_SUBFZE, iex_pkg::OP_SUBF, iex_pkg::OP_NEG};
    wire caw = op_reg inside {[iex_pkg::OP_ADDIC:iex_pkg::OP_SUBFZE]};
    wire cin_ca = op_reg inside {[iex_pkg::OP_ADDE:iex_pkg::OP_SUBFZE]};
    wire cin_one = op_reg inside {iex_pkg::OP_SUBFIC, iex_pkg::OP_SUBFC,
        iex_pkg::OP_SUBF, iex_pkg::OP_NEG};
    wire y_ones = op_reg inside {iex_pkg::OP_ADDME, iex_pkg::OP_SUBFME};
    wire y_zero = op_reg inside {iex_pkg::OP_ADDZE, iex_pkg::OP_SUBFZE, iex_pkg::OP_NEG};
    wire [31:0] x = xi ? ~a_reg : a_reg;
    wire [31:0] y = y_ones ? 32'hFFFFFFFF : y_zero ? 32'h00000000 : b_reg;
    wire cin = cin_one || (cin_ca && ca_reg);
    wire [32:0] sum = {1'b0, x} + {1'b0, y} + {32'h00000000, cin};
    wire add_ov = (x[31] == y[31]) && (sum[31] != x[31]);
    wire signed [63:0] prod_s = $signed(a_reg) * $signed(b_reg);
    wire [63:0] prod_u = {32'h00000000, a_reg} * {32'h00000000, b_reg};
    wire mul_lo = op_reg inside {iex_pkg::OP_MULLW, iex_pkg::OP_MULLI};
    wire [31:0] mul_res = mul_lo ? prod_s[31:0]
        : op_reg == iex_pkg::OP_MULHWU ? prod_u[63:32] : prod_s[63:32];
    wire mul_ov = prod_s[63:31] != {33{prod_s[31]}};
    // Short multipliers finish early; the length follows the second operand.
    wire fit16 = b_reg[31:15] == {17{b_reg[31]}}, fit24 = b_reg[31:23] == {9{b_reg[31]}};
    wire [5:0] mul_len = fit16 ? `IEX_EXE_MUL_FAST
        : fit24 ? `IEX_EXE_MUL_MID : `IEX_EXE_MUL_SLOW;
    // Divide paths; a zero divisor yields zero and sets overflow.
    wire dz = b_reg == 32'h00000000;
    wire signed [63:0] dvd_l = {a_reg, mq_reg};
    wire signed [63:0] dvs_l = {{32{b_reg[31]}}, b_reg};
    wire [63:0] q_l = dz ? 64'h0 : 64'(dvd_l / dvs_l);
    wire [63:0] r_l = dz ? 64'h0 : 64'(dvd_l % dvs_l);
    wire [31:0] q_s = dz ? 32'h0 : 32'($signed(a_reg) / $signed(b_reg));
    wire [31:0] r_s = dz ? 32'h0 : 32'($signed(a_reg) % $signed(b_reg));
    wire [31:0] q_u = dz ? 32'h0 : a_reg / b_reg;
    wire [31:0] div_res = op_reg == iex_pkg::OP_DIV ? q_l[31:0]
        : op_reg == iex_pkg::OP_DIVWU ? q_u : q_s;
    wire [31:0] div_mq = op_reg == iex_pkg::OP_DIV ? r_l[31:0]
        : op_reg == iex_pkg::OP_DIVS ? r_s : 32'h00000000;
    wire [31:0] res = is_mul || is_mulli ? mul_res : is_div ? div_res : sum[31:0];
    wire [31:0] mq_new = is_div ? div_mq : prod_s[31:0];
    wire ov_new = is_mul ? mul_ov : is_div ? dz : add_ov;
    wire oe_eff = oe_reg && !imf, so_new = so_reg || (oe_eff && ov_new);
    wire rc_eff = (rc_reg && !imf) || op_reg == iex_pkg::OP_ADDIC_REC;
    wire [3:0] rec_fld = {res[31], !res[31] && res != 32'h0, res == 32'h0, so_new};
    wire uns = op_reg inside {iex_pkg::OP_CMPL, iex_pkg::OP_CMPLI};
    wire slt = $signed(a_reg) < $signed(b_reg), sgt = $signed(a_reg) > $signed(b_reg);
    wire ult = a_reg < b_reg, ugt = a_reg > b_reg, eq = a_reg == b_reg;
    wire [3:0] cmp_fld = {uns ? ult : slt, uns ? ugt : sgt, eq, so_reg};
    wire trap_hit = |(fld_reg & {slt, sgt, eq, ult, ugt});
    wire ex_last = st_reg == iex_pkg::ST_EXE && cnt_reg == 6'h00;
    wire wb_last = st_reg == iex_pkg::ST_WB && cnt_reg == 6'h00;
    wire [5:0] exe_len = is_mul ? mul_len
        : is_mulli ? `IEX_EXE_MUL_FAST
        : is_div ? `IEX_EXE_DIV : `IEX_EXE_ONE;
    wire [5:0] wb_len = is_trap && trap_hit ? `IEX_WB_TRAP : `IEX_EXE_ONE;
    wire wr_go = !awready && !wready && !bvalid, rd_go = arvalid && arready;
    wire [31:0] wm = {{8{ws_reg[3]}}, {8{ws_reg[2]}}, {8{ws_reg[1]}}, {8{ws_reg[0]}}};
    wire w_mask = wr_go && aw_reg == `IEX_OFF_MASK && ws_reg[0];
    wire w_flags = wr_go && aw_reg == `IEX_OFF_FLAGS && ws_reg[0];
    wire w_mq = wr_go && aw_reg == `IEX_OFF_MQ;
    wire w_hit = aw_reg inside {`IEX_OFF_STATUS, `IEX_OFF_MASK, `IEX_OFF_FLAGS,
        `IEX_OFF_COND, `IEX_OFF_MQ, `IEX_OFF_STATE};
    wire r_sts = araddr == `IEX_OFF_STATUS;
    wire r_hit = araddr inside {`IEX_OFF_STATUS, `IEX_OFF_MASK, `IEX_OFF_FLAGS,
        `IEX_OFF_COND, `IEX_OFF_MQ, `IEX_OFF_STATE};
    wire [31:0] rd_mux = r_sts ? {29'h0, status_reg}
        : araddr == `IEX_OFF_MASK ? {29'h0, mask_reg}
        : araddr == `IEX_OFF_FLAGS ? {29'h0, so_reg, ov_reg, ca_reg}
        : araddr == `IEX_OFF_COND ? cr_reg
        : araddr == `IEX_OFF_MQ ? mq_reg
        : araddr == `IEX_OFF_STATE ? {24'h0, cnt_reg, st_reg} : 32'h0;
    // Events: retire, trap taken, overflow recorded.
    wire ev_ovf = ex_last && !is_cmp && !is_trap && oe_eff && ov_new;
    wire ev_trap = wb_last && is_trap && wb_data[0];
    wire [2:0] ev = {ev_ovf, ev_trap, wb_last || (ex_last && is_cmp)};
    wire [2:0] sts_clr = rd_go && r_sts ? status_reg : 3'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= iex_pkg::ST_IDLE;
            cnt_reg <= 6'h00;
            issue_ready <= 1'b0;
        end else if (ce) begin
            unique case (st_reg)
                iex_pkg::ST_IDLE: begin
                    issue_ready <= 1'b1;
                    if (take) begin
                        st_reg <= iex_pkg::ST_DEC;
                        issue_ready <= 1'b0;
                    end
                end
                iex_pkg::ST_DEC: begin
                    st_reg <= iex_pkg::ST_EXE;
                    cnt_reg <= exe_len - 6'h01;
                end
                iex_pkg::ST_EXE: begin
                    if (cnt_reg != 6'h00) begin
                        cnt_reg <= cnt_reg - 6'h01;
                    end else if (is_cmp) begin
                        st_reg <= iex_pkg::ST_IDLE;
                    end else begin
                        st_reg <= iex_pkg::ST_WB;
                        cnt_reg <= wb_len - 6'h01;
                    end
                end
                iex_pkg::ST_WB: begin
                    if (cnt_reg != 6'h00) begin
                        cnt_reg <= cnt_reg - 6'h01;
                    end else begin
                        st_reg <= iex_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end
    always_ff @(posedge aclk) begin
        if (take && ce) begin
            op_reg <= issue_op;
            a_reg <= r0_zero ? 32'h00000000 : issue_ra;
            b_reg <= b_in;
            dest_reg <= issue_dest;
            fld_reg <= issue_field;
            rc_reg <= issue_record;
            oe_reg <= issue_oe;
        end
    end
    // Writeback port; for traps wb_data[0] carries the taken flag.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wb_valid <= 1'b0;
            wb_dest <= 5'h00;
            wb_data <= 32'h00000000;
            trap_exception <= 1'b0;
        end else if (ce) begin
            trap_exception <= ev_trap;
            if (ex_last && !is_cmp) begin
                wb_valid <= !is_trap;
                wb_dest <= dest_reg;
                wb_data <= is_trap ? {31'h0, trap_hit} : res;
            end else if (wb_last) wb_valid <= 1'b0;
        end
    end
    // Architectural state; execute updates win over software writes.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {so_reg, ov_reg, ca_reg} <= 3'h0;
            cr_reg <= `IEX_CR_RST;
            mq_reg <= `IEX_MQ_RST;
            cr_fwd_valid <= 1'b0;
            cr_fwd_field <= 3'h0;
            cr_fwd_value <= 4'h0;
        end else if (ce) begin
            cr_fwd_valid <= ex_last && is_cmp;
            if (w_flags) {so_reg, ov_reg, ca_reg} <= wd_reg[2:0];
            if (w_mq) mq_reg <= (mq_reg & ~wm) | (wd_reg & wm);
            if (ex_last && (is_add || is_mul || is_mulli || is_div)) begin
                if (caw && is_add) ca_reg <= sum[32];
                if (oe_eff) begin
                    ov_reg <= ov_new;
                    so_reg <= so_new;
                end
                if (rc_eff) cr_reg[0] <= rec_fld;
                if (!is_add) mq_reg <= mq_new;
            end
            if (ex_last && is_cmp) begin
                cr_reg[fld_reg[2:0]] <= cmp_fld;
                cr_fwd_field <= fld_reg[2:0];
                cr_fwd_value <= cmp_fld;
            end
        end
    end
    // Register bus slave and interrupt status.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {awready, wready, arready} <= 3'h7;
            {bvalid, rvalid} <= 2'h0;
            {bresp, rresp} <= 4'h0;
            rdata <= 32'h00000000;
            aw_reg <= 8'h00;
            wd_reg <= 32'h00000000;
            ws_reg <= 4'h0;
            mask_reg <= `IEX_MASK_RST;
            status_reg <= 3'h0;
            irq <= 1'b0;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_reg <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wd_reg <= wdata;
                ws_reg <= wstrb;
                wready <= 1'b0;
            end
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp <= w_hit ? `IEX_RESP_OKAY : `IEX_RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
                {awready, wready} <= 2'h3;
            end
            if (w_mask) mask_reg <= wd_reg[2:0];
            if (rd_go) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_mux;
                rresp <= r_hit ? `IEX_RESP_OKAY : `IEX_RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
            status_reg <= (status_reg & ~sts_clr) | ev;
            irq <= |(((status_reg & ~sts_clr) | ev) & (w_mask ? wd_reg[2:0] : mask_reg));
        end
    end
    // Checks: cycle counters for the execute and writeback stays.
    always_ff @(posedge aclk) begin
        if (!aresetn || st_reg == iex_pkg::ST_DEC) begin
            exe_n <= 6'h00;
        end else if (ce && st_reg == iex_pkg::ST_EXE) begin
            exe_n <= exe_n + 6'h01;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn || st_reg == iex_pkg::ST_EXE) begin
            wb_n <= 6'h00;
        end else if (ce && st_reg == iex_pkg::ST_WB) begin
            wb_n <= wb_n + 6'h01;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);
    sequence s_dec_then_exe;
        st_reg == iex_pkg::ST_DEC ##1 st_reg == iex_pkg::ST_EXE;
    endsequence
    AST_ONE_DECODE: assert property (take |=> s_dec_then_exe)
        else $error("decode stage not one cycle");
    AST_ADD_ONE_EXE: assert property (ex_last && is_add |-> exe_n == 6'h00)
        else $error("add stayed more than one execute cycle");
    AST_FLAGS_NOT_WB: assert property (st_reg == iex_pkg::ST_WB && !wr_go
        |=> $stable({ca_reg, ov_reg, so_reg, cr_reg[0]}))
        else $error("flags changed during writeback");
    AST_IMM_NO_OV: assert property (ex_last && imf && !wr_go |=> $stable(ov_reg))
        else $error("immediate form changed overflow");
    AST_MUL_LEN: assert property (ex_last && is_mul
        |-> exe_n == 6'h04 || exe_n == 6'h08 || exe_n == 6'h09)
        else $error("multiply length not 5, 9 or 10");
    AST_MULLI_LEN: assert property (ex_last && is_mulli |-> exe_n == 6'h04)
        else $error("immediate multiply not 5 cycles");
    AST_DIV_LEN: assert property (ex_last && is_div |-> exe_n == 6'h23)
        else $error("divide not 36 cycles");
    AST_CMP_NO_WB: assert property (ex_last && is_cmp
        |=> st_reg == iex_pkg::ST_IDLE && !wb_valid)
        else $error("compare entered writeback");
    AST_CR_FWD: assert property (ex_last && is_cmp |=> cr_fwd_valid
        && cr_reg[cr_fwd_field] == cr_fwd_value)
        else $error("compare result not forwarded");
    AST_TRAP_WB: assert property (wb_last && is_trap
        |-> wb_n == (wb_data[0] ? 6'h15 : 6'h00))
        else $error("trap writeback length wrong");
    AST_WB_NEXT: assert property (ex_last && !is_cmp && !is_trap
        |=> wb_valid && st_reg == iex_pkg::ST_WB ##1 !wb_valid)
        else $error("writeback not right after execute");
endmodule

// ===== common/iex_cfg.svh
// Purpose: Offsets, reset values and cycle counts of the integer execute unit.
// Assumes: One 50 MHz clock; register map reached over AXI4-Lite.
// Notes: Counts are execute or writeback cycles of one instruction.
`ifndef IEX_CFG_SVH
`define IEX_CFG_SVH
`define IEX_OFF_STATUS 8'h00
`define IEX_OFF_MASK 8'h04
`define IEX_OFF_FLAGS 8'h08
`define IEX_OFF_COND 8'h0C
`define IEX_OFF_MQ 8'h10
`define IEX_OFF_STATE 8'h14
`define IEX_MASK_RST 3'h0
`define IEX_MQ_RST 32'h00000000
`define IEX_CR_RST 32'h00000000
`define IEX_EXE_ONE 6'h01
`define IEX_EXE_MUL_FAST 6'h05
`define IEX_EXE_MUL_MID 6'h09
`define IEX_EXE_MUL_SLOW 6'h0A
`define IEX_EXE_DIV 6'h24
`define IEX_WB_TRAP 6'h16
`define IEX_RESP_OKAY 2'h0
`define IEX_RESP_SLVERR 2'h2
`endif

// ===== common/iex_pkg.sv
// Purpose: Types shared by the integer execute unit and its users.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Operations are ordered so that classes form ranges.
package iex_pkg;
    typedef enum logic [4:0] {
        OP_ADDI, OP_ADDIS, OP_ADD, OP_ADDIC, OP_ADDIC_REC, OP_SUBFIC,
        OP_ADDC, OP_SUBFC, OP_ADDE, OP_SUBFE, OP_ADDME, OP_SUBFME,
        OP_ADDZE, OP_SUBFZE, OP_SUBF, OP_NEG,
        OP_MUL, OP_MULLW, OP_MULHW, OP_MULHWU, OP_MULLI,
        OP_DIV, OP_DIVS, OP_DIVW, OP_DIVWU,
        OP_CMP, OP_CMPL, OP_CMPI, OP_CMPLI, OP_TW, OP_TWI
    } iex_op_e;
    typedef enum logic [1:0] {ST_IDLE, ST_DEC, ST_EXE, ST_WB} iex_state_e;
endpackage

// ===== sim/iex_seq_model.sv
// Purpose: Decoder-side model that offers one instruction at a time and times its stages.
// Assumes: Issue handshake of the execute unit; one instruction in flight.
// Notes: Released operand lines carry the inverse of the last offer, never its old value.
module iex_seq_model (
    input wire logic aclk,
    output logic issue_valid,
    input wire logic issue_ready,
    output iex_pkg::iex_op_e issue_op,
    output logic [4:0] issue_dest,
    output logic [31:0] issue_ra,
    output logic [31:0] issue_rb,
    output logic [15:0] issue_imm,
    output logic issue_ra_is_r0,
    output logic issue_record,
    output logic issue_oe,
    output logic [4:0] issue_field,
    input wire logic wb_valid,
    input wire logic cr_fwd_valid,
    input wire logic trap_exception
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        issue_valid = 1'b0;
        issue_op = iex_pkg::OP_ADDI;
        issue_dest = 5'h03;
        issue_ra = 32'h0;
        issue_rb = 32'h0;
        issue_imm = 16'h0;
        issue_ra_is_r0 = 1'b0;
        issue_record = 1'b0;
        issue_oe = 1'b0;
        issue_field = 5'h00;
    end
    // Counts are sampling edges after the take edge, so a change made at edge k shows at k+1.
    task automatic run(input iex_pkg::iex_op_e op, input logic [31:0] a, input logic [31:0] b,
        input logic [15:0] im, input logic rec, input logic oe, input logic [4:0] f,
        output int lw, output int lc, output int lt, output int lr);
        int n;
        @(posedge aclk);
        issue_op <= op;
        issue_ra <= a;
        issue_rb <= b;
        issue_imm <= im;
        issue_record <= rec;
        issue_oe <= oe;
        issue_field <= f;
        issue_valid <= 1'b1;
        do @(posedge aclk); while (!issue_ready);
        issue_valid <= 1'b0;
        issue_ra <= ~a;
        issue_rb <= ~b;
        issue_imm <= ~im;
        n = 0;
        lw = 0;
        lc = 0;
        lt = 0;
        lr = 0;
        while (lr == 0 && n < 200) begin
            @(posedge aclk);
            n++;
            if (wb_valid && lw == 0) lw = n;
            if (cr_fwd_valid && lc == 0) lc = n;
            if (trap_exception && lt == 0) lt = n;
            if (issue_ready) lr = n;
        end
    endtask
endmodule

// ===== sim/iex_integer_execute_test.sv
// Purpose: Self-checking bench for the integer execute unit.
// Assumes: 50 MHz clock, synchronous active-low reset, AXI4-Lite register map.
// Notes: Stage latencies are measured by the decoder model in sampling edges.
`include "iex_cfg.svh"
module iex_integer_execute_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, issue_valid, issue_ready, issue_ra_is_r0, issue_record, issue_oe;
    iex_pkg::iex_op_e issue_op;
    logic [4:0] issue_dest, issue_field, wb_dest;
    logic [31:0] issue_ra, issue_rb, wb_data, rdata, wdata, rd;
    logic [15:0] issue_imm;
    logic wb_valid, cr_fwd_valid, trap_exception, irq, awready, wready, bvalid, arready, rvalid;
    logic [2:0] cr_fwd_field;
    logic [3:0] cr_fwd_value, wstrb;
    logic [7:0] awaddr, araddr;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic [1:0] bresp, rresp, resp;
    int bad_count, n_checks, lw, lc, lt, lr;
    int cyc = 0;
    iex_integer_execute i_iex_integer_execute (
        .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .issue_valid(issue_valid),
        .issue_ready(issue_ready), .issue_op(issue_op), .issue_dest(issue_dest),
        .issue_ra(issue_ra), .issue_rb(issue_rb), .issue_imm(issue_imm),
        .issue_ra_is_r0(issue_ra_is_r0), .issue_record(issue_record), .issue_oe(issue_oe),
        .issue_field(issue_field), .wb_valid(wb_valid), .wb_dest(wb_dest), .wb_data(wb_data),
        .cr_fwd_valid(cr_fwd_valid), .cr_fwd_field(cr_fwd_field), .cr_fwd_value(cr_fwd_value),
        .trap_exception(trap_exception), .irq(irq), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    iex_seq_model i_iex_seq_model (
        .aclk(aclk), .issue_valid(issue_valid), .issue_ready(issue_ready),
        .issue_op(issue_op), .issue_dest(issue_dest), .issue_ra(issue_ra),
        .issue_rb(issue_rb), .issue_imm(issue_imm), .issue_ra_is_r0(issue_ra_is_r0),
        .issue_record(issue_record), .issue_oe(issue_oe), .issue_field(issue_field),
        .wb_valid(wb_valid), .cr_fwd_valid(cr_fwd_valid), .trap_exception(trap_exception));
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic ex(input iex_pkg::iex_op_e op, input logic [31:0] a, input logic [31:0] b,
        input logic [15:0] im, input logic rec, input logic oe, input logic [4:0] f);
        i_iex_seq_model.run(op, a, b, im, rec, oe, f, lw, lc, lt, lr);
    endtask
    task automatic t_regs();
        axi_rd(`IEX_OFF_MQ, rd, resp);
        check("mq reset", rd, `IEX_MQ_RST);
        axi_rd(8'h40, rd, resp);
        check("unmapped rresp", resp, `IEX_RESP_SLVERR);
        axi_wr(8'h40, 32'hFFFFFFFF, resp);
        check("unmapped bresp", resp, `IEX_RESP_SLVERR);
        axi_rd(`IEX_OFF_FLAGS, rd, resp);
        check("flags reset", rd, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_add();
        ex(iex_pkg::OP_ADDI, 32'h7FFFFFFF, 32'h0, 16'h0001, 1'b1, 1'b1, 5'h00);
        check("addi data", wb_data, 32'h80000000);
        check("addi wb edge", lw, 3);
        check("addi ready edge", lr, 5);
        axi_rd(`IEX_OFF_FLAGS, rd, resp);
        check("addi flags", rd, 32'h0);
        ex(iex_pkg::OP_ADD, 32'h5, 32'h3, 16'h0, 1'b0, 1'b0, 5'h00);
        check("add data", wb_data, 32'h8);
        axi_rd(`IEX_OFF_COND, rd, resp);
        check("add no record", rd, `IEX_CR_RST);
        ex(iex_pkg::OP_ADD, 32'h7FFFFFFF, 32'h1, 16'h0, 1'b1, 1'b1, 5'h00);
        check("add dest", wb_dest, 5'h03);
        axi_rd(`IEX_OFF_FLAGS, rd, resp);
        check("add ov flags", rd, 32'h6);
        axi_rd(`IEX_OFF_COND, rd, resp);
        check("add record", rd, 32'h90000000);
        ex(iex_pkg::OP_ADDC, 32'hFFFFFFFF, 32'h1, 16'h0, 1'b0, 1'b0, 5'h00);
        check("addc data", wb_data, 32'h0);
        axi_rd(`IEX_OFF_FLAGS, rd, resp);
        check("addc flags", rd, 32'h7);
        $display("test add done");
    endtask
    task automatic t_cmp();
        iex_pkg::iex_op_e ops [4] = '{iex_pkg::OP_CMP, iex_pkg::OP_CMPL, iex_pkg::OP_CMPI,
            iex_pkg::OP_CMPLI};
        logic [31:0] ca [4] = '{32'h1, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h5};
        logic [31:0] cb [4] = '{32'h2, 32'h1, 32'hFFFFFFFF, 32'h0};
        logic [15:0] ci [4] = '{16'h0, 16'h0, 16'h0001, 16'h0005};
        int cf [4] = '{3, 2, 0, 1};
        logic [3:0] cv [4] = '{4'h8, 4'h4, 4'h8, 4'h2};
        axi_wr(`IEX_OFF_FLAGS, 32'h0, resp);
        for (int i = 0; i < 4; i++) begin
            ex(ops[i], ca[i], cb[i], ci[i], 1'b0, 1'b0, cf[i][4:0]);
            check("cmp value", cr_fwd_value, cv[i]);
            check("cmp field", cr_fwd_field, cf[i][2:0]);
            check("cmp fwd edge", lc, 3);
            check("cmp no wb", lw, 0);
            check("cmp ready edge", lr, 4);
            axi_rd(`IEX_OFF_COND, rd, resp);
            check("cmp cond", rd[(31 - 4 * cf[i]) -: 4], cv[i]);
        end
        $display("test cmp done");
    endtask
    task automatic t_mul();
        logic [31:0] mb [3] = '{32'h4, 32'h00100000, 32'h01000000};
        int mn [3] = '{`IEX_EXE_MUL_FAST, `IEX_EXE_MUL_MID, `IEX_EXE_MUL_SLOW};
        for (int i = 0; i < 3; i++) begin
            ex(iex_pkg::OP_MULLW, 32'h3, mb[i], 16'h0, 1'b0, 1'b0, 5'h00);
            check("mullw data", wb_data, mb[i] * 3);
            check("mullw wb edge", lw, 2 + mn[i]);
            check("mullw ready edge", lr, 4 + mn[i]);
        end
        ex(iex_pkg::OP_MULLI, 32'h3, 32'h01000000, 16'h0004, 1'b0, 1'b0, 5'h00);
        check("mulli data", wb_data, 32'hC);
        check("mulli wb edge", lw, 7);
        ex(iex_pkg::OP_MUL, 32'h00010000, 32'h00010003, 16'h0, 1'b0, 1'b0, 5'h00);
        check("mul high", wb_data, 32'h1);
        check("mul wb edge", lw, 11);
        axi_rd(`IEX_OFF_MQ, rd, resp);
        check("mul mq", rd, 32'h00030000);
        $display("test mul done");
    endtask
    task automatic t_div();
        iex_pkg::iex_op_e ops [4] = '{iex_pkg::OP_DIV, iex_pkg::OP_DIVS, iex_pkg::OP_DIVW,
            iex_pkg::OP_DIVWU};
        logic [31:0] da [4] = '{32'h0, 32'd100, 32'd100, 32'hFFFFFFFF};
        logic [31:0] db [4] = '{32'd7, 32'd7, 32'd7, 32'd2};
        logic [31:0] dq [4] = '{32'd14, 32'd14, 32'd14, 32'h7FFFFFFF};
        axi_wr(`IEX_OFF_MQ, 32'd100, resp);
        for (int i = 0; i < 4; i++) begin
            ex(ops[i], da[i], db[i], 16'h0, 1'b0, 1'b0, 5'h00);
            check("div quotient", wb_data, dq[i]);
            check("div wb edge", lw, 2 + `IEX_EXE_DIV);
            axi_rd(`IEX_OFF_MQ, rd, resp);
            if (i < 2) check("div remainder", rd, 32'd2);
        end
        $display("test div done");
    endtask
    task automatic t_trap();
        axi_wr(`IEX_OFF_MASK, 32'h2, resp);
        ex(iex_pkg::OP_TW, 32'h1, 32'h2, 16'h0, 1'b0, 1'b0, 5'h08);
        check("trap untaken exc", lt, 0);
        check("trap untaken ready", lr, 5);
        check("trap untaken irq", irq, 1'b0);
        ex(iex_pkg::OP_TWI, 32'h5, 32'h6, 16'h0005, 1'b0, 1'b0, 5'h04);
        check("trap taken exc", lt, 3 + `IEX_WB_TRAP);
        repeat (2) @(posedge aclk);
        check("trap irq", irq, 1'b1);
        axi_rd(`IEX_OFF_STATUS, rd, resp);
        check("trap status", rd[1], 1'b1);
        axi_rd(`IEX_OFF_STATUS, rd, resp);
        check("status cleared", rd[1], 1'b0);
        repeat (3) @(posedge aclk);
        check("irq cleared", irq, 1'b0);
        $display("test trap done");
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        bad_count = 0;
        n_checks = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_add();
        t_cmp();
        t_mul();
        t_div();
        t_trap();
        conclude();
    end
endmodule
